/* design/fsg_pkg.sv */
// Package for the flash access security gate
package fsg_pkg;
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 9;
    localparam int DATA_W = 8;
    localparam int LOCK_W = 8;
    // Default lock byte page and reserved area, page numbers (128-byte pages)
    localparam logic [PAGE_W-1:0] LOCK_PAGE_RST = 9'h07b;
    localparam logic [PAGE_W-1:0] RSV_PAGE_LO = 9'h07c;
    localparam logic [PAGE_W-1:0] RSV_PAGE_HI = 9'h07f;
    localparam logic [ADDR_W-1:0] LIMIT_RST = 16'h0000;
    localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hff;
    localparam logic [DATA_W-1:0] LOCK_RST = 8'hff;
    typedef enum logic [1:0] {
        FSG_SRC_DEBUG = 2'h0,
        FSG_SRC_LOW = 2'h1,
        FSG_SRC_HIGH = 2'h3
    } fsg_src_t;
    typedef enum logic [1:0] {
        FSG_OP_READ = 2'h0,
        FSG_OP_WRITE = 2'h1,
        FSG_OP_ERASE = 2'h2,
        FSG_OP_MASS = 2'h3
    } fsg_op_t;
endpackage

/* design/fsg_classify.sv */
// Requester classification for the flash access security gate
`timescale 1ns/1ps
module fsg_classify (
    input wire logic dbg_req,
    input wire logic [fsg_pkg::ADDR_W-1:0] pc_addr,
    input wire logic [fsg_pkg::ADDR_W-1:0] limit_addr,
    output fsg_pkg::fsg_src_t src
);
    import fsg_pkg::*;
    always_comb begin
        if (dbg_req) begin
            src = FSG_SRC_DEBUG; // [RULE_01]
        end else if (pc_addr < limit_addr) begin
            src = FSG_SRC_LOW; // [RULE_17]
        end else begin
            src = FSG_SRC_HIGH; // [RULE_17]
        end
    end
endmodule

/* design/fsg_gate.sv */
// Flash access security gate between requesters and the flash array
// How it works
// RULE_01: Classify request: debug, low firmware, high firmware
// RULE_02: Debug may access unlocked pages
// RULE_03: Debug refused on locked pages
// RULE_04: Debug may always read lock bytes
// RULE_05: Debug may always add locks
// RULE_06: Debug erase of unlocked lock page clears locks
// RULE_07: Locked lock page cleared only by mass erase
// RULE_08: Reserved area always refused
// RULE_09: Lock bytes ignore firmware requests
// RULE_10: Low firmware accesses all but lock-page erase
// RULE_11: Firmware never erases lock page
// RULE_12: Firmware may read and write lock page
// RULE_13: High firmware accesses pages at/above limit
// RULE_14: High firmware refused below limit
// RULE_15: Instruction fetches below limit still allowed
// RULE_16: Refused ops never reach array or requester
// RULE_17: Side decided by executing instruction address
`timescale 1ns/1ps
module fsg_gate (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_dbg,
    input wire logic req_fetch,
    input wire fsg_pkg::fsg_op_t req_op,
    input wire logic [fsg_pkg::ADDR_W-1:0] req_addr,
    input wire logic [fsg_pkg::DATA_W-1:0] req_wdata,
    input wire logic [fsg_pkg::ADDR_W-1:0] pc_addr,
    input wire logic [fsg_pkg::ADDR_W-1:0] limit_addr,
    input wire logic [fsg_pkg::DATA_W-1:0] flash_rdata,
    input wire logic [fsg_pkg::PAGE_W-1:0] lock_page,
    output logic flash_rd,
    output logic flash_wr,
    output logic flash_erase,
    output logic flash_mass_erase,
    output logic [fsg_pkg::ADDR_W-1:0] flash_addr,
    output logic [fsg_pkg::DATA_W-1:0] flash_wdata,
    output logic resp_valid,
    output logic resp_denied,
    output logic [fsg_pkg::DATA_W-1:0] resp_rdata,
    output logic [fsg_pkg::LOCK_W-1:0] lock_bits
);
    import fsg_pkg::*;

    localparam int PAGE_LSB = ADDR_W - PAGE_W;

    fsg_src_t src;
    logic [PAGE_W-1:0] page;
    logic [PAGE_W-1:0] limit_page;
    logic is_lock_page;
    logic is_rsv;
    logic page_locked;
    logic adds_locks;
    logic allow;
    logic [LOCK_W-1:0] lock_reg;
    logic rd_pend_reg;

    // Lock byte: one bit per eighth of flash, 0 means locked (erased = all open)
    function automatic logic locked_by(input logic [LOCK_W-1:0] lk,
                                       input logic [PAGE_W-1:0] pg);
        locked_by = ~lk[pg[PAGE_W-1 -: 3]];
    endfunction

    fsg_classify u_classify (
        .dbg_req(req_dbg),
        .pc_addr(pc_addr),
        .limit_addr(limit_addr),
        .src(src)
    );

    assign page = req_addr[ADDR_W-1:PAGE_LSB];
    assign limit_page = limit_addr[ADDR_W-1:PAGE_LSB];
    assign is_lock_page = (page == lock_page);
    assign is_rsv = (page >= RSV_PAGE_LO) && (page <= RSV_PAGE_HI);
    assign page_locked = locked_by(lock_reg, page);
    // Flash writes only clear bits, so a write may only add locks
    assign adds_locks = ((req_wdata | lock_reg) == lock_reg);

    always_comb begin
        allow = 1'b0;
        if (is_rsv) begin
            allow = 1'b0; // [RULE_08]
        end else begin
            case (src)
                FSG_SRC_DEBUG: begin
                    if (req_op == FSG_OP_MASS) begin
                        allow = 1'b1; // [RULE_07]
                    end else if (is_lock_page && req_op == FSG_OP_READ) begin
                        allow = 1'b1; // [RULE_04]
                    end else if (is_lock_page && req_op == FSG_OP_WRITE && adds_locks) begin
                        allow = 1'b1; // [RULE_05]
                    end else begin
                        allow = !page_locked; // [RULE_02] [RULE_03] [RULE_06] [RULE_07]
                    end
                end
                FSG_SRC_LOW: begin
                    // Lock bits not consulted for firmware [RULE_09]
                    allow = !(req_op == FSG_OP_MASS) &&
                            !(is_lock_page && req_op == FSG_OP_ERASE); // [RULE_10] [RULE_11] [RULE_12]
                end
                FSG_SRC_HIGH: begin
                    if (req_op == FSG_OP_MASS) begin
                        allow = 1'b0;
                    end else if (is_lock_page) begin
                        allow = (req_op != FSG_OP_ERASE); // [RULE_11] [RULE_12]
                    end else if (req_fetch && req_op == FSG_OP_READ) begin
                        allow = 1'b1; // [RULE_15]
                    end else begin
                        allow = (page >= limit_page); // [RULE_13] [RULE_14]
                    end
                end
                default: allow = 1'b0;
            endcase
        end
    end

    // Strobes to the array only for granted requests
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flash_rd <= 1'b0;
            flash_wr <= 1'b0;
            flash_erase <= 1'b0;
            flash_mass_erase <= 1'b0;
            flash_addr <= '0;
            flash_wdata <= '0;
        end else begin
            flash_rd <= req_valid && allow && req_op == FSG_OP_READ; // [RULE_16]
            flash_wr <= req_valid && allow && req_op == FSG_OP_WRITE; // [RULE_16]
            flash_erase <= req_valid && allow && req_op == FSG_OP_ERASE; // [RULE_16]
            flash_mass_erase <= req_valid && allow && req_op == FSG_OP_MASS; // [RULE_16]
            if (req_valid && allow) begin
                flash_addr <= req_addr;
                flash_wdata <= req_wdata;
            end
        end
    end

    // Shadow of the lock byte; the array holds the real copy
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lock_reg <= LOCK_RST;
        end else if (req_valid && allow) begin
            if (req_op == FSG_OP_MASS) begin
                lock_reg <= LOCK_RST; // [RULE_07]
            end else if (req_op == FSG_OP_ERASE && is_lock_page) begin
                lock_reg <= LOCK_RST; // [RULE_06]
            end else if (req_op == FSG_OP_WRITE && is_lock_page) begin
                lock_reg <= lock_reg & req_wdata; // [RULE_05] [RULE_12]
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lock_bits <= LOCK_RST;
        end else begin
            lock_bits <= lock_reg;
        end
    end

    // Answer: one cycle after take for refusals, writes and erases (none if a read answer is due in that cycle), two for reads
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_pend_reg <= 1'b0;
            resp_valid <= 1'b0;
            resp_denied <= 1'b0;
            resp_rdata <= BLANK_BYTE;
        end else begin
            rd_pend_reg <= req_valid && allow && req_op == FSG_OP_READ;
            resp_valid <= 1'b0;
            resp_denied <= 1'b0;
            if (rd_pend_reg) begin
                resp_valid <= 1'b1;
                resp_rdata <= flash_rdata;
            end else if (req_valid && !allow) begin
                resp_valid <= 1'b1;
                resp_denied <= 1'b1;
                resp_rdata <= BLANK_BYTE; // [RULE_16]
            end else if (req_valid && req_op != FSG_OP_READ) begin
                resp_valid <= 1'b1;
            end
        end
    end
endmodule

/* verification/fsg_gate_props.sv */
// Checker for the flash access security gate
`timescale 1ns/1ps
module fsg_gate_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_dbg,
    input wire logic req_fetch,
    input wire fsg_pkg::fsg_op_t req_op,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] pc_addr,
    input wire logic [15:0] limit_addr,
    input wire logic [8:0] lock_page,
    input wire logic flash_rd,
    input wire logic flash_wr,
    input wire logic flash_erase,
    input wire logic flash_mass_erase,
    input wire logic [15:0] flash_addr,
    input wire logic resp_valid,
    input wire logic resp_denied,
    input wire logic [7:0] resp_rdata,
    input wire logic [7:0] lock_bits
);
    import fsg_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    wire [8:0] pg = req_addr[15:7];
    wire rsv = pg >= RSV_PAGE_LO && pg <= RSV_PAGE_HI;
    wire fw_hi = !req_dbg && pc_addr >= limit_addr;
    wire rq = req_valid && !req_dbg && !rsv;
    sequence s_refused;
        resp_valid && resp_denied;
    endsequence
    sequence s_rd_grant;
        flash_rd ##1 resp_valid && !resp_denied;
    endsequence
    rsv_refuse_a: assert property (req_valid && rsv |=> s_refused)
        else $error("reserved access granted");
    no_strobe_a: assert property (s_refused |-> !(flash_rd || flash_wr || flash_erase
        || flash_mass_erase)) else $error("refused op reached array");
    blank_data_a: assert property (s_refused |-> resp_rdata == BLANK_BYTE)
        else $error("refused read leaked data");
    fw_lock_erase_a: assert property (rq && req_op == FSG_OP_ERASE && pg == lock_page
        |=> s_refused) else $error("firmware erased lock page");
    high_below_a: assert property (rq && fw_hi && !req_fetch && pg < limit_addr[15:7]
        && pg != lock_page |=> s_refused) else $error("high firmware reached low page");
    low_write_a: assert property (rq && !fw_hi && req_op == FSG_OP_WRITE
        |=> flash_wr && flash_addr == $past(req_addr)) else $error("low write blocked");
    fetch_ok_a: assert property (rq && fw_hi && req_fetch && req_op == FSG_OP_READ
        |=> s_rd_grant) else $error("fetch blocked");
    dbg_read_a: assert property (req_valid && req_dbg && req_op == FSG_OP_READ && !rsv
        && (lock_bits[req_addr[15:13]] || pg == lock_page) |=> s_rd_grant)
        else $error("debug read blocked");
endmodule

/* verification/fsg_flash_model.sv */
// Flash array stand-in answering reads within the strobe cycle
`timescale 1ns/1ps
module fsg_flash_model (
    input wire logic ref_clk,
    input wire logic flash_rd,
    input wire logic [15:0] flash_addr,
    output logic [7:0] flash_rdata
);
    logic [7:0] junk_reg = 8'h00;
    // Bus shows junk_reg outside reads; it negates itself each cycle from 0, so it stays at 0
    always_ff @(posedge ref_clk) junk_reg <= ~junk_reg + 8'h01;
    assign flash_rdata = flash_rd ? (flash_addr[7:0] ^ 8'h5a) : junk_reg;
endmodule

/* verification/test_flash_access_security_gate.sv */
// Bench for the flash access security gate
`timescale 1ns/1ps
module test_flash_access_security_gate;
    import fsg_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_dbg = 1'b0, req_fetch = 1'b0;
    fsg_op_t req_op = FSG_OP_READ;
    logic [15:0] req_addr = 16'h0000, pc_addr = 16'h0000, limit_addr = 16'h4000, flash_addr;
    logic [7:0] req_wdata = 8'hff, flash_rdata, flash_wdata, resp_rdata, lock_bits;
    logic [8:0] lock_page = LOCK_PAGE_RST;
    logic flash_rd, flash_wr, flash_erase, flash_mass_erase, resp_valid, resp_denied;
    int n_fail = 0, n_checks = 0, cyc = 0;
    fsg_gate dut_u (.ref_clk, .rst_n, .req_valid, .req_dbg, .req_fetch, .req_op, .req_addr,
        .req_wdata, .pc_addr, .limit_addr, .flash_rdata, .lock_page, .flash_rd, .flash_wr,
        .flash_erase, .flash_mass_erase, .flash_addr, .flash_wdata, .resp_valid,
        .resp_denied, .resp_rdata, .lock_bits);
    fsg_flash_model flash_u (.ref_clk, .flash_rd, .flash_addr, .flash_rdata);
    task automatic print_verdict();
        if (n_fail == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // One request; answers are awaited for a bounded three cycles
    task automatic xfer(input logic d, f, input fsg_op_t op, input logic [15:0] a, input logic den);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_dbg <= d;
        req_fetch <= f;
        req_op <= op;
        req_addr <= a;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        #1;
        for (int i = 0; i < 3 && resp_valid !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        check($sformatf("answer %h", a), {7'h00, resp_valid}, 8'h01);
        check($sformatf("denied %h", a), {7'h00, resp_denied}, {7'h00, den});
        if (den || op == FSG_OP_READ)
            check($sformatf("data %h", a), resp_rdata, den ? 8'hff : a[7:0] ^ 8'h5a);
    endtask
    task automatic t_debug();
        xfer(1, 0, FSG_OP_READ, 16'h0085, 0);
        xfer(1, 0, FSG_OP_WRITE, 16'h2000, 0);
        xfer(1, 0, FSG_OP_READ, 16'h3d80, 0);
        xfer(1, 0, FSG_OP_WRITE, 16'h3d80, 0);
        xfer(1, 0, FSG_OP_READ, 16'h3e10, 1);
        xfer(1, 0, FSG_OP_ERASE, 16'h3d80, 0);
        check("lock bits", lock_bits, 8'hff);
        xfer(1, 0, FSG_OP_MASS, 16'h0000, 0);
    endtask
    task automatic t_low();
        pc_addr <= 16'h0100;
        xfer(0, 0, FSG_OP_WRITE, 16'h5000, 0);
        xfer(0, 0, FSG_OP_ERASE, 16'h1000, 0);
        xfer(0, 0, FSG_OP_ERASE, 16'h3d80, 1);
        xfer(0, 0, FSG_OP_WRITE, 16'h3d80, 0);
        xfer(0, 0, FSG_OP_WRITE, 16'h3f00, 1);
        xfer(0, 0, FSG_OP_MASS, 16'h0000, 1);
    endtask
    task automatic t_high();
        pc_addr <= 16'h8000;
        xfer(0, 0, FSG_OP_READ, 16'h1000, 1);
        xfer(0, 1, FSG_OP_READ, 16'h1000, 0);
        xfer(0, 0, FSG_OP_ERASE, 16'h6000, 0);
        xfer(0, 0, FSG_OP_READ, 16'h3d80, 0);
        xfer(0, 0, FSG_OP_ERASE, 16'h3d80, 1);
        xfer(0, 0, FSG_OP_WRITE, 16'h0200, 1);
    endtask
    // Lock bits really change here, so clearing and refusal are both visible
    task automatic t_locks();
        @(posedge ref_clk);
        req_wdata <= 8'hfe;
        pc_addr <= 16'h0100;
        xfer(1, 0, FSG_OP_WRITE, 16'h3d80, 0);
        check("lock wdata", flash_wdata, 8'hfe);
        @(posedge ref_clk);
        #1;
        check("lock bits", lock_bits, 8'hfe);
        xfer(1, 0, FSG_OP_READ, 16'h0085, 1);
        xfer(0, 0, FSG_OP_READ, 16'h0085, 0);
        xfer(1, 0, FSG_OP_ERASE, 16'h3d80, 0);
        check("erase strobe", {7'h00, flash_erase}, 8'h01);
        @(posedge ref_clk);
        #1;
        check("lock bits", lock_bits, 8'hff);
        @(posedge ref_clk);
        req_wdata <= 8'hfd;
        xfer(1, 0, FSG_OP_WRITE, 16'h3d80, 0);
        xfer(1, 0, FSG_OP_ERASE, 16'h3d80, 1);
        check("erase strobe", {7'h00, flash_erase}, 8'h00);
        xfer(1, 0, FSG_OP_READ, 16'h3d80, 0);
        xfer(1, 0, FSG_OP_MASS, 16'h0000, 0);
        check("mass strobe", {7'h00, flash_mass_erase}, 8'h01);
        @(posedge ref_clk);
        #1;
        check("lock bits", lock_bits, 8'hff);
    endtask
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_debug();
        t_low();
        t_high();
        t_locks();
        print_verdict();
    end
endmodule
bind fsg_gate fsg_gate_props chk_u (.ref_clk, .rst_n, .req_valid, .req_dbg, .req_fetch,
    .req_op, .req_addr, .pc_addr, .limit_addr, .lock_page, .flash_rd, .flash_wr, .flash_erase,
    .flash_mass_erase, .flash_addr, .resp_valid, .resp_denied, .resp_rdata, .lock_bits);
